// File: logic/dm_pkg.sv
// constants, field layouts and carriers of the data memory map
// assumes one core clock shared by core, map and peripheral blocks
package dm_pkg;
	// ==========================================
	// address space
	localparam int DM_ADDR_W = 12;
	localparam int DM_SPACE = 4096;
	localparam logic [11:0] DM_SFR_BASE = 12'hF60;
	localparam logic [11:0] DM_CORE_BASE = 12'hFE0;
	localparam logic [7:0] DM_ALIAS_ROW = 8'hFE;
	// ==========================================
	// core register offsets
	localparam logic [11:0] DM_BANK_SEL = 12'hFE0;
	localparam logic [11:0] DM_PTR1_LO = 12'hFE1;
	localparam logic [11:0] DM_PTR1_HI = 12'hFE2;
	localparam logic [11:0] DM_INDIRECT_PLUS_WORKING_1 = 12'hFE3;
	localparam logic [11:0] DM_INDIRECT_PRE_INCREMENT_1 = 12'hFE4;
	localparam logic [11:0] DM_INDIRECT_POST_DECREMENT_1 = 12'hFE5;
	localparam logic [11:0] DM_INDIRECT_POST_INCREMENT_1 = 12'hFE6;
	localparam logic [11:0] DM_INDOP1 = 12'hFE7;
	localparam logic [11:0] DM_WORKING = 12'hFE8;
	localparam logic [11:0] DM_PTR0_LO = 12'hFE9;
	localparam logic [11:0] DM_PTR0_HI = 12'hFEA;
	localparam logic [11:0] DM_INDIRECT_PLUS_WORKING_0 = 12'hFEB;
	localparam logic [11:0] DM_INDIRECT_PRE_INCREMENT_0 = 12'hFEC;
	localparam logic [11:0] DM_INDIRECT_POST_DECREMENT_0 = 12'hFED;
	localparam logic [11:0] DM_POSTINC0 = 12'hFEE;
	localparam logic [11:0] DM_INDOP0 = 12'hFEF;
	localparam logic [11:0] DM_INT_CTL3 = 12'hFF0;
	localparam logic [11:0] DM_INT_CTL2 = 12'hFF1;
	localparam logic [11:0] DM_INT_CTL = 12'hFF2;
	localparam logic [11:0] DM_PROD_LO = 12'hFF3;
	localparam logic [11:0] DM_PROD_HI = 12'hFF4;
	localparam logic [11:0] DM_TAB_LATCH = 12'hFF5;
	localparam logic [11:0] DM_TAB_PTR_LO = 12'hFF6;
	localparam logic [11:0] DM_TAB_PTR_HI = 12'hFF7;
	localparam logic [11:0] DM_TAB_PTR_UP = 12'hFF8;
	localparam logic [11:0] DM_PC_LO = 12'hFF9;
	localparam logic [11:0] DM_PC_LATCH_HI = 12'hFFA;
	localparam logic [11:0] DM_PC_LATCH_UP = 12'hFFB;
	localparam logic [11:0] DM_STACK_PTR = 12'hFFC;
	localparam logic [11:0] DM_TOS_LO = 12'hFFD;
	localparam logic [11:0] DM_TOS_HI = 12'hFFE;
	localparam logic [11:0] DM_TOS_UP = 12'hFFF;
	// ==========================================
	// peripheral locations with special gating
	localparam logic [11:0] DM_MEM_IF_CTL = 12'hF9C;
	localparam logic [11:0] DM_DIR_J = 12'hF9A;
	localparam logic [11:0] DM_DIR_H = 12'hF99;
	localparam logic [11:0] DM_LAT_J = 12'hF91;
	localparam logic [11:0] DM_LAT_H = 12'hF90;
	localparam logic [11:0] DM_PORT_J = 12'hF88;
	localparam logic [11:0] DM_PORT_H = 12'hF87;
	localparam logic [11:0] DM_PAR_SLAVE_CTL = 12'hFB0;
	// ==========================================
	// core entries 31..0 = FFFh..FE0h, one byte each
	localparam logic [255:0] DM_CORE_RESET = {104'h0, 8'h00, 8'hFF, 8'hC0, 128'h0};
	localparam logic [255:0] DM_CORE_MASK =
		256'h1FFFFFDF_1FFFFF3F_FFFFFFFF_FFFFFFFF_00000000_000FFFFF_00000000_000FFF0F;
	// indirect alias kinds by low three address bits
	localparam logic [2:0] DM_IND_INDIRECT_PLUS_WORKING = 3'h3;
	localparam logic [2:0] DM_IND_INDIRECT_PRE_INCREMENT = 3'h4;
	localparam logic [2:0] DM_IND_INDIRECT_POST_DECREMENT = 3'h5;
	localparam logic [2:0] DM_IND_INDIRECT_POST_INCREMENT = 3'h6;
	localparam logic [2:0] DM_IND_PLAIN = 3'h7;
	// ==========================================
	// carriers
	typedef enum logic [1:0] {DM_BANKED, DM_FULL, DM_PTR0, DM_PTR1} dm_mode_t;
	typedef struct packed {
		logic valid;
		logic write;
		dm_mode_t mode;
		logic [7:0] operand;
		logic [11:0] fullAddr;
		logic [7:0] wdata;
	} dm_req_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} dm_rsp_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic [11:0] addr;
		logic [7:0] wdata;
	} dm_periph_t;
	typedef struct packed {
		logic valid;
		logic [4:0] idx;
		logic [7:0] data;
	} dm_hw_t;
endpackage

// File: logic/dm_map.sv
// data memory address decoder, core register file and general RAM
// assumes core, peripherals and this block share clk; mode pin is async
//
// Operation
// - general RAM never reset, keeps contents
// - F60h to FFFh decode to special registers
// - all lower addresses are read/write general RAM
// - empty special locations read zero, ignore writes
// - special registers static, shared core and peripherals
// - absent registers on small variant read zero
// - indirect alias addresses hold no storage
// - parallel slave control needs big variant, mcu mode
// - direct and pointer-based indirect accesses both work
// - twelve-bit address, 4096 byte space
// - sixteen banks, bank nibble, upper bits unimplemented
// - pointers hold full address, ignore bank select
`timescale 1ns/10ps
module dm_map #(
	parameter bit HIGH_PIN_VARIANT = 1'b1,
	parameter int GPR_DEPTH = 3936
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire dm_pkg::dm_req_t req,
	output dm_pkg::dm_rsp_t rsp,
	input wire logic mcuModePin,
	output dm_pkg::dm_periph_t periphReq,
	input wire logic [7:0] periphRdata,
	input wire logic periphHit,
	input wire dm_pkg::dm_hw_t hwWr,
	output logic [255:0] coreRegs
);
	// ==========================================
	// indices into the core register file
	localparam logic [4:0] IDX_BANK = dm_pkg::DM_BANK_SEL[4:0];
	localparam logic [4:0] IDX_P0L = dm_pkg::DM_PTR0_LO[4:0];
	localparam logic [4:0] IDX_P0H = dm_pkg::DM_PTR0_HI[4:0];
	localparam logic [4:0] IDX_P1L = dm_pkg::DM_PTR1_LO[4:0];
	localparam logic [4:0] IDX_P1H = dm_pkg::DM_PTR1_HI[4:0];
	localparam logic [4:0] IDX_WORK = dm_pkg::DM_WORKING[4:0];
	localparam logic [11:0] GPR_LIMIT = 12'(GPR_DEPTH);

	function automatic logic [7:0] maskOf(input logic [4:0] i);
		return dm_pkg::DM_CORE_MASK[{i, 3'b000} +: 8];
	endfunction

	logic [7:0] coreReg_r [32];
	logic [7:0] coreReg_nxt [32];
	logic [7:0] gprMem [GPR_DEPTH];
	dm_pkg::dm_rsp_t rsp_r;
	dm_pkg::dm_rsp_t rsp_nxt;
	logic mcuModeMeta_r;
	logic mcuMode_r;
	logic [11:0] dirAddr;
	logic [11:0] effAddr;
	logic [11:0] ptrVal;
	logic [11:0] ptrOffs;
	logic [11:0] ptrNew;
	logic [2:0] kind;
	logic isAlias;
	logic viaPtr;
	logic ptrOne;
	logic inCore;
	logic inPeriph;
	logic inGpr;
	logic absent;
	logic pspBlock;
	logic gprWe;

	// ==========================================
	// mode pin synchroniser
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			mcuModeMeta_r <= 1'b0;
			mcuMode_r <= 1'b0;
		end
		else
		begin
			mcuModeMeta_r <= mcuModePin;
			mcuMode_r <= mcuModeMeta_r;
		end
	end

	// ==========================================
	// address formation
	always_comb
	begin
		// banked form uses only the low bank nibble
		if (req.mode == dm_pkg::DM_BANKED)
			dirAddr = {coreReg_r[IDX_BANK][3:0], req.operand};
		else
			dirAddr = req.fullAddr;
		// direct hit on an alias address goes through its pointer
		isAlias = (req.mode == dm_pkg::DM_BANKED || req.mode == dm_pkg::DM_FULL)
			&& dirAddr[11:4] == dm_pkg::DM_ALIAS_ROW && dirAddr[2:0] >= dm_pkg::DM_IND_INDIRECT_PLUS_WORKING;
		viaPtr = isAlias || req.mode == dm_pkg::DM_PTR0 || req.mode == dm_pkg::DM_PTR1;
		// alias row bit 3 clear selects pointer one
		ptrOne = (req.mode == dm_pkg::DM_PTR1) || (isAlias && !dirAddr[3]);
		kind = isAlias ? dirAddr[2:0] : dm_pkg::DM_IND_PLAIN;
		if (ptrOne)
			ptrVal = {coreReg_r[IDX_P1H][3:0], coreReg_r[IDX_P1L]};
		else
			ptrVal = {coreReg_r[IDX_P0H][3:0], coreReg_r[IDX_P0L]};
		// signed working register offset for the plus-working alias
		if (kind == dm_pkg::DM_IND_INDIRECT_PRE_INCREMENT)
			ptrOffs = 12'h001;
		else if (kind == dm_pkg::DM_IND_INDIRECT_PLUS_WORKING)
			ptrOffs = {{4{coreReg_r[IDX_WORK][7]}}, coreReg_r[IDX_WORK]};
		else
			ptrOffs = 12'h000;
		effAddr = viaPtr ? ptrVal + ptrOffs : dirAddr;
		// pointer value left behind by the auto-modify aliases
		ptrNew = (kind == dm_pkg::DM_IND_INDIRECT_POST_DECREMENT) ? ptrVal - 12'h001 : ptrVal + 12'h001;
	end

	// ==========================================
	// region decode
	always_comb
	begin
		inCore = effAddr >= dm_pkg::DM_CORE_BASE;
		inGpr = effAddr < dm_pkg::DM_SFR_BASE && effAddr < GPR_LIMIT;
		absent = !HIGH_PIN_VARIANT && (effAddr == dm_pkg::DM_MEM_IF_CTL
			|| effAddr == dm_pkg::DM_DIR_J || effAddr == dm_pkg::DM_DIR_H
			|| effAddr == dm_pkg::DM_LAT_J || effAddr == dm_pkg::DM_LAT_H
			|| effAddr == dm_pkg::DM_PORT_J || effAddr == dm_pkg::DM_PORT_H);
		pspBlock = effAddr == dm_pkg::DM_PAR_SLAVE_CTL && !(HIGH_PIN_VARIANT && mcuMode_r);
		inPeriph = effAddr >= dm_pkg::DM_SFR_BASE && !inCore && !absent && !pspBlock;
		gprWe = req.valid && req.write && inGpr;
	end

	// peripheral window request, a same-cycle strobe
	always_comb
	begin
		periphReq.valid = req.valid && inPeriph;
		periphReq.write = req.write;
		periphReq.addr = effAddr;
		periphReq.wdata = req.wdata;
	end

	// ==========================================
	// core register file
	always_comb
	begin
		for (int i = 0; i < 32; i++)
			coreReg_nxt[i] = coreReg_r[i];
		// auto-modify of the pointer, lowest priority
		if (req.valid && viaPtr && (kind == dm_pkg::DM_IND_INDIRECT_POST_INCREMENT
			|| kind == dm_pkg::DM_IND_INDIRECT_POST_DECREMENT || kind == dm_pkg::DM_IND_INDIRECT_PRE_INCREMENT))
		begin
			if (ptrOne)
			begin
				coreReg_nxt[IDX_P1L] = ptrNew[7:0];
				coreReg_nxt[IDX_P1H] = {4'h0, ptrNew[11:8]};
			end
			else
			begin
				coreReg_nxt[IDX_P0L] = ptrNew[7:0];
				coreReg_nxt[IDX_P0H] = {4'h0, ptrNew[11:8]};
			end
		end
		// masking drops unimplemented bits and alias entries
		if (req.valid && req.write && inCore)
			coreReg_nxt[effAddr[4:0]] = req.wdata & maskOf(effAddr[4:0]);
		// peripheral or core hardware update wins, so a flag set is never lost
		if (hwWr.valid)
			coreReg_nxt[hwWr.idx] = hwWr.data & maskOf(hwWr.idx);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 32; i++)
				coreReg_r[i] <= dm_pkg::DM_CORE_RESET[i * 8 +: 8];
		end
		else
		begin
			for (int i = 0; i < 32; i++)
				coreReg_r[i] <= coreReg_nxt[i];
		end
	end

	// register contents visible to every peripheral block
	genvar g;
	generate
		for (g = 0; g < 32; g++)
		begin : gExport
			assign coreRegs[g * 8 +: 8] = coreReg_r[g];
		end
	endgenerate

	// ==========================================
	// general RAM, deliberately without reset so contents survive any reset
	always_ff @(posedge clk)
	begin
		if (gprWe)
			gprMem[effAddr] <= req.wdata;
	end

	// ==========================================
	// read answer, one cycle after the request
	always_comb
	begin
		rsp_nxt.valid = req.valid && !req.write;
		rsp_nxt.data = 8'h00;
		if (req.valid && !req.write)
		begin
			if (inCore)
				rsp_nxt.data = coreReg_r[effAddr[4:0]];
			else if (inPeriph)
				rsp_nxt.data = periphHit ? periphRdata : 8'h00;
			else if (inGpr)
				rsp_nxt.data = gprMem[effAddr];
			else
				rsp_nxt.data = 8'h00;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rsp_r <= '0;
		else
			rsp_r <= rsp_nxt;
	end

	assign rsp = rsp_r;

	// ==========================================
	// checks
	readLatency_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && !req.write) |=> rsp.valid ##1 (rsp.valid == $past(req.valid && !req.write)))
		else $error("read answer not one cycle after request");

	bankForm_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && req.mode == dm_pkg::DM_BANKED && !isAlias)
		|-> effAddr == {coreRegs[3:0], req.operand})
		else $error("banked address not bank nibble and operand");

	bankUpper_a: assert property (@(posedge clk) disable iff (!rst_n)
		coreRegs[7:4] == 4'h0)
		else $error("bank select upper bits not zero");

	emptyZero_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && !req.write && effAddr >= dm_pkg::DM_SFR_BASE && !inCore && !periphHit)
		|=> rsp.valid && rsp.data == 8'h00)
		else $error("empty special location read not zero");

	absentZero_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && !req.write && absent) |-> !periphReq.valid ##1 (rsp.data == 8'h00))
		else $error("absent register reached or not zero");

	pspGate_a: assert property (@(posedge clk) disable iff (!rst_n)
		(periphReq.valid && periphReq.addr == dm_pkg::DM_PAR_SLAVE_CTL)
		|-> HIGH_PIN_VARIANT && mcuMode_r)
		else $error("parallel slave control reached while disabled");

	aliasEmpty_a: assert property (@(posedge clk) disable iff (!rst_n)
		coreRegs[dm_pkg::DM_INDOP0[4:0] * 8 +: 8] == 8'h00
		&& coreRegs[dm_pkg::DM_INDIRECT_PLUS_WORKING_1[4:0] * 8 +: 8] == 8'h00)
		else $error("indirect alias holds a value");

	splitWrite_a: assert property (@(posedge clk) disable iff (!rst_n)
		gprWe |-> effAddr < dm_pkg::DM_SFR_BASE && !periphReq.valid)
		else $error("special region write reached general RAM");

	gprLoop_a: assert property (@(posedge clk) disable iff (!rst_n)
		(gprWe ##1 (req.valid && !req.write && inGpr && effAddr == $past(effAddr)))
		|=> rsp.data == $past(req.wdata, 2))
		else $error("general RAM read back differs from write");

	ptrReach_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && req.mode == dm_pkg::DM_PTR1)
		|-> effAddr == {coreRegs[IDX_P1H * 8 +: 4], coreRegs[IDX_P1L * 8 +: 8]})
		else $error("pointer access ignores pointer value");

	indirect_post_increment_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && !req.write && isAlias && kind == dm_pkg::DM_IND_INDIRECT_POST_INCREMENT && !ptrOne && !hwWr.valid)
		|=> {coreRegs[IDX_P0H * 8 +: 4], coreRegs[IDX_P0L * 8 +: 8]} == $past(ptrVal) + 12'h001)
		else $error("post-increment did not step pointer");

	hwWrite_a: assert property (@(posedge clk) disable iff (!rst_n)
		hwWr.valid |=> coreReg_r[$past(hwWr.idx)] == ($past(hwWr.data) & maskOf($past(hwWr.idx))))
		else $error("hardware update lost");

	// ==========================================
	// pointer aliases, answers and reset values
	// pre-increment must address one past the pointer, not the pointer itself
	preIncAddr_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && isAlias && kind == dm_pkg::DM_IND_INDIRECT_PRE_INCREMENT)
		|-> effAddr == ptrVal + 12'h001)
		else $error("pre-increment address wrong");

	// post-decrement leaves pointer zero one lower; a core write to it would win
	indirect_post_decrement_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && isAlias && kind == dm_pkg::DM_IND_INDIRECT_POST_DECREMENT && !ptrOne
		&& !hwWr.valid && !(req.write && inCore))
		|=> {coreRegs[IDX_P0H * 8 +: 4], coreRegs[IDX_P0L * 8 +: 8]} == $past(ptrVal) - 12'h001)
		else $error("post-decrement did not step pointer");

	// plus-working offset is signed, so pointers can reach backwards
	plusWork_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && isAlias && kind == dm_pkg::DM_IND_INDIRECT_PLUS_WORKING)
		|-> effAddr == ptrVal + {{4{coreRegs[IDX_WORK * 8 + 7]}}, coreRegs[IDX_WORK * 8 +: 8]})
		else $error("plus-working address wrong");

	// plus-working never moves the pointer
	plusKeep_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && isAlias && kind == dm_pkg::DM_IND_INDIRECT_PLUS_WORKING && !ptrOne
		&& !hwWr.valid && !(req.write && inCore))
		|=> {coreRegs[IDX_P0H * 8 +: 4], coreRegs[IDX_P0L * 8 +: 8]} == $past(ptrVal))
		else $error("plus-working moved pointer");

	// a write landing on an alias address stores nothing
	aliasWrite_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && req.write && inCore && effAddr[4:0] == dm_pkg::DM_INDOP1[4:0] && !hwWr.valid)
		|=> coreRegs[dm_pkg::DM_INDOP1[4:0] * 8 +: 8] == 8'h00)
		else $error("alias write stored a value");

	// general RAM writes stay inside the implemented depth
	gprSide_a: assert property (@(posedge clk) disable iff (!rst_n)
		gprWe |-> !inCore && effAddr < GPR_LIMIT)
		else $error("general RAM write out of range");

	// core register reads answer the value held before the access
	coreRead_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && !req.write && inCore)
		|=> rsp.data == $past(coreReg_r[effAddr[4:0]]))
		else $error("core register read wrong");

	// owned peripheral places pass their data through unchanged
	periphRead_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && !req.write && inPeriph && periphHit)
		|=> rsp.data == $past(periphRdata))
		else $error("peripheral read data lost");

	// the peripheral window never covers core registers or general RAM
	periphWin_a: assert property (@(posedge clk) disable iff (!rst_n)
		periphReq.valid |-> periphReq.addr >= dm_pkg::DM_SFR_BASE
		&& periphReq.addr < dm_pkg::DM_CORE_BASE)
		else $error("peripheral request outside window");

	// blocked, absent and unbacked places answer zero
	blockedZero_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && !req.write && !inCore && !inPeriph && !inGpr)
		|=> rsp.valid && rsp.data == 8'h00)
		else $error("blocked location read not zero");

	// pointer high bytes keep only the address nibble
	ptrUpper_a: assert property (@(posedge clk) disable iff (!rst_n)
		coreRegs[IDX_P0H * 8 + 4 +: 4] == 4'h0 && coreRegs[IDX_P1H * 8 + 4 +: 4] == 4'h0)
		else $error("pointer upper bits not zero");

	// writes give no answer, so the core never waits on one
	writeQuiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && req.write) |=> !rsp.valid)
		else $error("answer after write");

	// no request, no answer
	idleQuiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		!req.valid |=> !rsp.valid)
		else $error("answer without request");

	// core write lands masked unless hardware updates that register the same cycle
	coreWrite_a: assert property (@(posedge clk) disable iff (!rst_n)
		(req.valid && req.write && inCore && !hwWr.valid)
		|=> coreReg_r[$past(effAddr[4:0])] == ($past(req.wdata) & maskOf($past(effAddr[4:0]))))
		else $error("core register write lost");

	// reset loads every core register, unlike general RAM
	resetValue_a: assert property (@(posedge clk)
		!rst_n |=> coreRegs == dm_pkg::DM_CORE_RESET)
		else $error("core register reset value wrong");
endmodule

// File: dv/dm_periph_model.sv
// peripheral side stand-in for the data memory map
// assumes periphReq is combinational from the core request on clk
`timescale 1ns/10ps
module dm_periph_model (
	input wire logic clk,
	input wire dm_pkg::dm_periph_t periphReq,
	output logic [7:0] periphRdata,
	output logic periphHit
);
	logic [7:0] idleBus = 8'hA5;
	// ==========================================
	// owned places from F80h up answer a fixed pattern; idle bus keeps changing
	always_comb
	begin
		periphHit = periphReq.valid && periphReq.addr >= 12'hF80;
		periphRdata = periphReq.valid ? (periphReq.addr[7:0] ^ 8'h5A) : idleBus;
	end
	// toggle so stale data never passes for an answer
	always_ff @(posedge clk)
		idleBus <= ~idleBus;
endmodule

// File: dv/testbench.sv
// self-checking bench for the data memory map with a queue-free byte model
// assumes dm_pkg and dm_periph_model are compiled first
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failCount++; \
	$display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module testbench;
	logic clk, rst_n, mcuModePin, periphHit, pv;
	dm_pkg::dm_req_t req;
	dm_pkg::dm_rsp_t rsp;
	dm_pkg::dm_periph_t periphReq;
	dm_pkg::dm_hw_t hwWr;
	logic [7:0] periphRdata, d;
	logic [255:0] coreRegs;
	logic [7:0] general_purpose_ram [int];
	logic [7:0] cr [32];
	logic [11:0] a;
	logic [11:0] spots [5];
	dm_pkg::dm_rsp_t rspLo;
	dm_pkg::dm_periph_t periphReqLo;
	logic [7:0] periphRdataLo;
	logic periphHitLo;
	int failCount, compares, seed;
	dm_map u_dut (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp), .mcuModePin(mcuModePin),
		.periphReq(periphReq), .periphRdata(periphRdata), .periphHit(periphHit), .hwWr(hwWr),
		.coreRegs(coreRegs));
	dm_periph_model u_per (.clk(clk), .periphReq(periphReq), .periphRdata(periphRdata),
		.periphHit(periphHit));
	// small variant shares the request stream so absent registers can be checked
	dm_map #(.HIGH_PIN_VARIANT(1'b0)) u_dut_lo (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rspLo),
		.mcuModePin(mcuModePin), .periphReq(periphReqLo), .periphRdata(periphRdataLo),
		.periphHit(periphHitLo), .hwWr(hwWr), .coreRegs());
	dm_periph_model u_per_lo (.clk(clk), .periphReq(periphReqLo), .periphRdata(periphRdataLo),
		.periphHit(periphHitLo));
	// ==========================================
	// clock, 40 ns period
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ==========================================
	// reference model
	function automatic logic [11:0] ptrAddr(input int p);
		return p ? {cr[2][3:0], cr[1]} : {cr[10][3:0], cr[9]};
	endfunction
	function automatic logic [11:0] aliasAddr(input logic [11:0] f);
		logic [11:0] b;
		b = ptrAddr(!f[3]);
		if (f[2:0] == dm_pkg::DM_IND_INDIRECT_PRE_INCREMENT)
			return b + 12'h001;
		if (f[2:0] == dm_pkg::DM_IND_INDIRECT_PLUS_WORKING)
			return b + {{4{cr[8][7]}}, cr[8]};
		return b;
	endfunction
	function automatic logic isAliasF(input logic [11:0] f);
		return f[11:4] == dm_pkg::DM_ALIAS_ROW && f[2:0] >= dm_pkg::DM_IND_INDIRECT_PLUS_WORKING;
	endfunction
	task automatic bump(input logic [11:0] f);
		logic [11:0] b;
		b = ptrAddr(!f[3]);
		b = (f[2:0] == dm_pkg::DM_IND_INDIRECT_POST_DECREMENT) ? b - 12'h001 : b + 12'h001;
		cr[f[3] ? 9 : 1] = b[7:0];
		cr[f[3] ? 10 : 2] = {4'h0, b[11:8]};
	endtask
	function automatic logic [11:0] resolve(input dm_pkg::dm_mode_t m, input logic [11:0] f);
		case (m)
			dm_pkg::DM_BANKED: return {cr[0][3:0], f[7:0]};
			dm_pkg::DM_FULL: return isAliasF(f) ? aliasAddr(f) : f;
			dm_pkg::DM_PTR0: return ptrAddr(0);
			default: return ptrAddr(1);
		endcase
	endfunction
	function automatic logic [7:0] expRead(input logic [11:0] x);
		if (x < dm_pkg::DM_SFR_BASE)
			return general_purpose_ram[x];
		if (x >= dm_pkg::DM_CORE_BASE)
			return cr[x[4:0]];
		if (x == dm_pkg::DM_PAR_SLAVE_CTL && !mcuModePin)
			return 8'h00;
		return (x >= 12'hF80) ? (x[7:0] ^ 8'h5A) : 8'h00;
	endfunction
	task automatic modelWrite(input logic [11:0] x, input logic [7:0] v);
		if (x < dm_pkg::DM_SFR_BASE)
			general_purpose_ram[x] = v;
		else if (x >= dm_pkg::DM_CORE_BASE)
			cr[x[4:0]] = v & dm_pkg::DM_CORE_MASK[8*x[4:0] +: 8];
	endtask
	task automatic resetModel();
		for (int k = 0; k < 32; k++)
			cr[k] = dm_pkg::DM_CORE_RESET[8*k +: 8];
	endtask
	task automatic chkRegs();
		for (int k = 0; k < 32; k++)
			`CHK(coreRegs[8*k +: 8], cr[k])
	endtask
	// one access: launch after an edge, taken at the next, answer one cycle later
	task automatic acc(input logic w, input dm_pkg::dm_mode_t m, input logic [11:0] f, input logic [7:0] v);
		logic [11:0] x;
		x = resolve(m, f);
		@(posedge clk);
		req <= '{1'b1, w, m, f[7:0], f, v};
		#1;
		pv = periphReq.valid;
		if (pv)
		begin
			`CHK(periphReq.addr, x)
			`CHK(periphReq.wdata, v)
		end
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
		if (m == dm_pkg::DM_FULL && isAliasF(f) && f[2:0] >= dm_pkg::DM_IND_INDIRECT_PRE_INCREMENT
			&& f[2:0] <= dm_pkg::DM_IND_INDIRECT_POST_INCREMENT)
			bump(f);
		if (w)
			modelWrite(x, v);
		else
		begin
			`CHK(rsp.valid, 1'b1)
			`CHK(rsp.data, expRead(x))
		end
	endtask
	task automatic doReset();
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		resetModel();
		@(posedge clk);
		#1;
	endtask
	task automatic giveVerdict();
		$display("compares=%0d mismatches=%0d", compares, failCount);
		if (failCount == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================
	// watchdog
	initial
	begin
		repeat (20000) @(posedge clk);
		failCount++;
		giveVerdict();
	end
	// ==========================================
	// main sequence
	initial
	begin
		seed = 32'hf171;
		rst_n = 1'b0;
		mcuModePin = 1'b0;
		req = '0;
		hwWr = '0;
		doReset();
		chkRegs();
		// random general RAM traffic over the whole lower space
		repeat (40)
		begin
			a = 12'($unsigned($random(seed)) % 3936);
			d = 8'($random(seed));
			acc(1'b1, dm_pkg::DM_FULL, a, d);
			acc(1'b0, dm_pkg::DM_FULL, a, 8'h00);
			`CHK(pv, 1'b0)
		end
		// banked and pointer access, bank upper nibble dropped
		repeat (8)
		begin
			acc(1'b1, dm_pkg::DM_FULL, dm_pkg::DM_BANK_SEL, 8'($random(seed)));
			a = resolve(dm_pkg::DM_BANKED, {4'h0, 8'($random(seed))} & 12'h07F);
			acc(1'b1, dm_pkg::DM_BANKED, a, 8'($random(seed)));
			acc(1'b0, dm_pkg::DM_FULL, a, 8'h00);
			acc(1'b1, dm_pkg::DM_FULL, dm_pkg::DM_PTR0_LO, 8'($random(seed)));
			acc(1'b1, dm_pkg::DM_FULL, dm_pkg::DM_PTR0_HI, 8'($unsigned($random(seed)) % 15));
			acc(1'b1, dm_pkg::DM_FULL, dm_pkg::DM_PTR1_LO, 8'($random(seed)));
			acc(1'b1, dm_pkg::DM_FULL, dm_pkg::DM_PTR1_HI, 8'($unsigned($random(seed)) % 15));
			acc(1'b1, dm_pkg::DM_PTR0, 12'h000, 8'($random(seed)));
			acc(1'b0, dm_pkg::DM_FULL, dm_pkg::DM_INDOP0, 8'h00);
			acc(1'b1, dm_pkg::DM_PTR1, 12'h000, 8'($random(seed)));
			acc(1'b0, dm_pkg::DM_PTR1, 12'h000, 8'h00);
			acc(1'b0, dm_pkg::DM_FULL, dm_pkg::DM_INDOP1, 8'h00);
			// auto-modify aliases only ever touch places written just before
			acc(1'b1, dm_pkg::DM_FULL, dm_pkg::DM_WORKING, 8'h01);
			acc(1'b1, dm_pkg::DM_FULL, dm_pkg::DM_POSTINC0, 8'($random(seed)));
			acc(1'b1, dm_pkg::DM_FULL, dm_pkg::DM_INDIRECT_POST_DECREMENT_0, 8'($random(seed)));
			acc(1'b0, dm_pkg::DM_FULL, dm_pkg::DM_INDIRECT_PRE_INCREMENT_0, 8'h00);
			acc(1'b0, dm_pkg::DM_FULL, dm_pkg::DM_INDIRECT_POST_DECREMENT_0, 8'h00);
			acc(1'b0, dm_pkg::DM_FULL, dm_pkg::DM_INDIRECT_PLUS_WORKING_0, 8'h00);
			acc(1'b0, dm_pkg::DM_FULL, dm_pkg::DM_POSTINC0, 8'h00);
		end
		// special region edges, a gap, two owned places and the top place below the core registers
		spots = '{12'hF60, 12'hF7F, 12'hF80, 12'hF9C, 12'hFDF};
		foreach (spots[k])
		begin
			acc(1'b1, dm_pkg::DM_FULL, spots[k], 8'hFF);
			acc(1'b0, dm_pkg::DM_FULL, spots[k], 8'h00);
			`CHK(pv, 1'b1)
			if (spots[k] == dm_pkg::DM_MEM_IF_CTL)
				`CHK(rspLo.data, 8'h00)
		end
		// slave port control gated by the synchronised mode pin
		acc(1'b0, dm_pkg::DM_FULL, dm_pkg::DM_PAR_SLAVE_CTL, 8'h00);
		`CHK(pv, 1'b0)
		mcuModePin <= 1'b1;
		repeat (3) @(posedge clk);
		acc(1'b0, dm_pkg::DM_FULL, dm_pkg::DM_PAR_SLAVE_CTL, 8'h00);
		`CHK(pv, 1'b1)
		`CHK(rspLo.data, 8'h00)
		// back-to-back write then read of one general RAM place
		@(posedge clk);
		req <= '{1'b1, 1'b1, dm_pkg::DM_FULL, 8'h00, 12'h200, 8'h3C};
		@(posedge clk);
		req.write <= 1'b0;
		@(posedge clk);
		req.valid <= 1'b0;
		general_purpose_ram[12'h200] = 8'h3C;
		#1;
		`CHK(rsp.data, 8'h3C)
		// hardware update of the working register
		@(posedge clk);
		hwWr <= '{1'b1, 5'd8, 8'hC3};
		@(posedge clk);
		hwWr.valid <= 1'b0;
		cr[8] = 8'hC3;
		#1;
		chkRegs();
		// general RAM survives a reset, core registers do not
		acc(1'b1, dm_pkg::DM_FULL, 12'h123, 8'hA5);
		doReset();
		chkRegs();
		acc(1'b0, dm_pkg::DM_FULL, 12'h123, 8'h00);
		giveVerdict();
	end
endmodule
